// *** rtl/sso_pkg.sv ***
// package: register map, field layout, timing and types of the starter control block
package sso_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_RATED = 8'h04;
   localparam logic [7:0] ADDR_RAMP  = 8'h08;
   localparam logic [7:0] ADDR_STAT  = 8'h0C;
   localparam logic [7:0] ADDR_IST   = 8'h10;
   localparam logic [7:0] ADDR_IMASK = 8'h14;
   // control field positions
   localparam int CTRL_CLS_LSB = 0;
   localparam int CTRL_AUTO    = 2;
   // reset values
   localparam logic [2:0]  CTRL_RST  = 3'h1;
   localparam logic [7:0]  RATED_RST = 8'h00;
   localparam logic [15:0] RAMP_RST  = 16'h0000;
   localparam logic [3:0]  IRQ_RST   = 4'h0;
   // trip class codes
   localparam logic [1:0] CLS_OFF = 2'h0;
   localparam logic [1:0] CLS_10  = 2'h1;
   localparam logic [1:0] CLS_15  = 2'h2;
   localparam logic [1:0] CLS_20  = 2'h3;
   // class trip times at 7.2 x rated current, in ms
   localparam logic [14:0] CLS10_MS = 15'h2710;
   localparam logic [14:0] CLS15_MS = 15'h3A98;
   localparam logic [14:0] CLS20_MS = 15'h4E20;
   // 7.2 x rated leaves 6.2 x rated of excess: ratio 62 / 10
   localparam logic [5:0] OVL_MUL = 6'h3E;
   localparam logic [3:0] OVL_DIV = 4'hA;
   // timing
   localparam int CLK_HZ      = 20_000_000;
   localparam int MS_PER_S    = 1000;
   localparam int MS_TICK_CYC = CLK_HZ / MS_PER_S;
   localparam int TEST_HOLD_S = 5;
   localparam int ENTER_S     = 2;
   localparam int CONF_S      = 1;
   localparam logic [15:0] TEST_MS  = 16'(TEST_HOLD_S * MS_PER_S);
   localparam logic [15:0] ENTER_MS = 16'(ENTER_S * MS_PER_S);
   localparam logic [15:0] CONF_MS  = 16'(CONF_S * MS_PER_S);
   localparam int FLASH_HALF_MS = 250;
   localparam int FLICK_HALF_MS = 62;
   // interrupt bit positions
   localparam int EV_TRIP  = 0;
   localparam int EV_BYP   = 1;
   localparam int EV_SAVE  = 2;
   localparam int EV_RATED = 3;
   // programming sequence
   typedef enum logic [1:0] {SSO_P_IDLE, SSO_P_ARM, SSO_P_SHOW, SSO_P_SEL} sso_prog_t;
   // front panel lamps
   typedef struct packed {
      logic health_green;
      logic health_red;
      logic phase_green;
      logic fault_red;
      logic trip_red;
      logic ack_auto;
   } sso_led_t;
endpackage

// *** rtl/sso_starter_ctrl.sv ***
// starter_output_and_setup_logic: overload, trip test, bypass, relay and programming control
module sso_starter_ctrl
   import sso_pkg::*;
#(
   parameter int          TICK_CYC  = MS_TICK_CYC,
   parameter int          FLASH_MS  = FLASH_HALF_MS,
   parameter int          FLICK_MS  = FLICK_HALF_MS,
   parameter logic [7:0]  MAX_RATED = 8'h64
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        start_input,
   input  wire logic        ack_test_button,
   input  wire logic        reset_behaviour_button,
   input  wire logic        startup_detected,
   input  wire logic [7:0]  motor_current,
   output logic             motor_on,
   output logic             full_voltage,
   output logic             bypass_close,
   output logic             startup_complete_output,
   output logic             follow_relay,
   output logic             fault_relay,
   output sso_led_t         leds,
   output logic             irq
);
   localparam int TW = $clog2(TICK_CYC);

   logic [TW-1:0] tick_cnt_q;
   logic          tick;
   logic [2:0]    ctrl_q;
   logic [7:0]    rated_q;
   logic [15:0]   ramp_q;
   logic [3:0]    ist_q;
   logic [3:0]    imask_q;
   logic [31:0]   prdata_q;
   logic [15:0]   ack_ms_q;
   logic [15:0]   rst_ms_q;
   logic          ack_prev_q;
   logic          rst_prev_q;
   logic          ack_used_q;
   logic [31:0]   acc_q;
   logic          trip_q;
   logic          run_q;
   logic          bypass_q;
   logic          start_prev_q;
   logic [15:0]   rd_ms_q;
   logic          follow_q;
   logic          mode_q;
   logic          sel_q;
   sso_prog_t     prog_q;
   sso_prog_t     prog_d;
   logic [8:0]    flash_cnt_q;
   logic [8:0]    flick_cnt_q;
   logic          flash_q;
   logic          flick_q;
   sso_led_t      leds_q;
   logic          rated_fault_q;
   logic          bypass_prev_q;

   // bus decode
   wire setup    = psel & ~penable;
   wire acc_wr   = psel & penable & pwrite;
   wire hit_ctrl = paddr == ADDR_CTRL;
   wire hit_rate = paddr == ADDR_RATED;
   wire hit_ramp = paddr == ADDR_RAMP;
   wire hit_stat = paddr == ADDR_STAT;
   wire hit_ist  = paddr == ADDR_IST;
   wire hit_imsk = paddr == ADDR_IMASK;
   wire mapped   = hit_ctrl | hit_rate | hit_ramp | hit_stat | hit_ist | hit_imsk;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = prdata_q;

   // configuration fields
   wire [1:0] cls      = ctrl_q[CTRL_CLS_LSB +: 2];
   wire       auto_rst = ctrl_q[CTRL_AUTO];
   wire       rated_fault = rated_q > MAX_RATED;

   // millisecond tick divider
   assign tick = tick_cnt_q == TW'(TICK_CYC - 1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) tick_cnt_q <= '0;
      else tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
   end

   // register writes and read data capture
   wire [3:0] ev;
   wire [31:0] stat_w = {26'h0, prog_q != SSO_P_IDLE, mode_q, bypass_q,
                         trip_q, rated_fault_q, run_q};
   wire [31:0] rd_mux = hit_ctrl ? {29'h0, ctrl_q} :
                        hit_rate ? {24'h0, rated_q} :
                        hit_ramp ? {16'h0, ramp_q} :
                        hit_stat ? stat_w :
                        hit_ist  ? {28'h0, ist_q} :
                        hit_imsk ? {28'h0, imask_q} : 32'h0;
   wire [3:0] w1c = (acc_wr & hit_ist) ? pwdata[3:0] : 4'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q   <= CTRL_RST;
         rated_q  <= RATED_RST;
         ramp_q   <= RAMP_RST;
         imask_q  <= IRQ_RST;
         ist_q    <= IRQ_RST;
         prdata_q <= 32'h0;
      end else begin
         if (acc_wr & hit_ctrl) ctrl_q <= pwdata[2:0];
         if (acc_wr & hit_rate) rated_q <= pwdata[7:0];
         if (acc_wr & hit_ramp) ramp_q <= pwdata[15:0];
         if (acc_wr & hit_imsk) imask_q <= pwdata[3:0];
         ist_q <= (ist_q & ~w1c) | ev; // set wins over clear
         if (setup) prdata_q <= rd_mux;
      end
   end
   assign irq = |(ist_q & imask_q);

   // button hold timers in ms
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_ms_q   <= 16'h0;
         rst_ms_q   <= 16'h0;
         ack_prev_q <= 1'b0;
         rst_prev_q <= 1'b0;
      end else begin
         ack_prev_q <= ack_test_button;
         rst_prev_q <= reset_behaviour_button;
         if (!ack_test_button) ack_ms_q <= 16'h0;
         else if (tick && ack_ms_q != 16'hFFFF) ack_ms_q <= ack_ms_q + 16'h1;
         if (!reset_behaviour_button) rst_ms_q <= 16'h0;
         else if (tick && rst_ms_q != 16'hFFFF) rst_ms_q <= rst_ms_q + 16'h1;
      end
   end
   wire ack_long  = ack_ms_q > CONF_MS;
   wire rst_long  = rst_ms_q > ENTER_MS;
   wire rst_press = reset_behaviour_button & ~rst_prev_q;
   wire ack_rel   = ~ack_test_button & ack_prev_q;

   // programming sequence
   wire save = (prog_q == SSO_P_SEL) & ack_long;
   always_comb begin
      prog_d = prog_q;
      unique case (prog_q)
         SSO_P_IDLE: if (rst_long && !ack_test_button) prog_d = SSO_P_ARM;
         SSO_P_ARM: begin
            if (!reset_behaviour_button) prog_d = SSO_P_IDLE;
            else if (ack_long) prog_d = SSO_P_SHOW;
         end
         SSO_P_SHOW: if (!ack_test_button) prog_d = SSO_P_SEL;
         SSO_P_SEL: if (ack_long) prog_d = SSO_P_IDLE;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prog_q <= SSO_P_IDLE;
         mode_q <= 1'b0;
         sel_q  <= 1'b0;
      end else begin
         prog_q <= prog_d;
         if (prog_q == SSO_P_ARM && prog_d == SSO_P_SHOW) sel_q <= mode_q;
         if (prog_q == SSO_P_SEL && rst_press) sel_q <= ~sel_q;
         if (save) mode_q <= sel_q;
      end
   end

   // ack press consumed by programming must not test or clear a trip
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ack_used_q <= 1'b0;
      else if (!ack_test_button) ack_used_q <= 1'b0;
      else if (prog_q != SSO_P_IDLE) ack_used_q <= 1'b1;
   end

   // overload accumulator of excess current per ms
   wire [14:0] cls_ms = (cls == CLS_10) ? CLS10_MS :
                        (cls == CLS_15) ? CLS15_MS : CLS20_MS;
   wire [35:0] acc_x10 = 36'(acc_q) * 36'(OVL_DIV);
   wire [35:0] ovl_lim = 36'(cls_ms) * 36'(OVL_MUL) * 36'(rated_q);
   wire        over    = motor_current > rated_q;
   wire [31:0] excess  = 32'(motor_current - rated_q);
   wire [31:0] deficit = 32'(rated_q - motor_current);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) acc_q <= 32'h0;
      else if (cls == CLS_OFF) acc_q <= 32'h0;
      else if (tick && over) acc_q <= acc_q + excess;
      else if (tick) acc_q <= (acc_q > deficit) ? acc_q - deficit : 32'h0;
   end
   wire ovl_trip  = (cls != CLS_OFF) && rated_q != 8'h0 && acc_x10 >= ovl_lim;
   wire test_fire = ack_test_button && ack_ms_q > TEST_MS && !ack_used_q &&
                    prog_q == SSO_P_IDLE;
   wire trip_set  = ovl_trip | test_fire;
   wire trip_clr  = ack_rel && ack_prev_q && !ack_used_q && ack_ms_q <= TEST_MS;

   // trip latch: a new trip wins over an acknowledge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) trip_q <= 1'b0;
      else if (trip_set) trip_q <= 1'b1;
      else if (trip_clr) trip_q <= 1'b0;
   end

   // motor run, bypass and ramp-down
   wire run_ok = start_input & ~trip_set & ~trip_q & ~rated_fault;
   wire start_fell = start_prev_q & ~start_input;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q         <= 1'b0;
         bypass_q      <= 1'b0;
         start_prev_q  <= 1'b0;
         rd_ms_q       <= 16'h0;
         rated_fault_q <= 1'b0;
         bypass_prev_q <= 1'b0;
      end else begin
         run_q         <= run_ok;
         start_prev_q  <= start_input;
         rated_fault_q <= rated_fault;
         bypass_prev_q <= bypass_q;
         if (!run_ok) bypass_q <= 1'b0;
         else if (startup_detected && run_q) bypass_q <= 1'b1;
         if (start_input) rd_ms_q <= 16'h0;
         else if (start_fell) rd_ms_q <= ramp_q;
         else if (tick && rd_ms_q != 16'h0) rd_ms_q <= rd_ms_q - 16'h1;
      end
   end
   wire ramping = ~start_input & (rd_ms_q != 16'h0 | (start_fell & ramp_q != 16'h0));
   assign motor_on                = run_q;
   assign bypass_close            = bypass_q;
   assign startup_complete_output = bypass_q;
   assign full_voltage            = bypass_q;
   assign fault_relay             = trip_q;

   // mode-selectable relay
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) follow_q <= 1'b0;
      else if (!mode_q) follow_q <= start_input;
      else follow_q <= start_input | ramping;
   end
   assign follow_relay = follow_q;

   // blink dividers, flash slow and flicker fast
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_cnt_q <= 9'h0;
         flick_cnt_q <= 9'h0;
         flash_q     <= 1'b0;
         flick_q     <= 1'b0;
      end else if (tick) begin
         flash_cnt_q <= (flash_cnt_q == 9'(FLASH_MS - 1)) ? 9'h0 : flash_cnt_q + 9'h1;
         flick_cnt_q <= (flick_cnt_q == 9'(FLICK_MS - 1)) ? 9'h0 : flick_cnt_q + 9'h1;
         if (flash_cnt_q == 9'(FLASH_MS - 1)) flash_q <= ~flash_q;
         if (flick_cnt_q == 9'(FLICK_MS - 1)) flick_q <= ~flick_q;
      end
   end

   // lamp selection
   wire in_show = prog_q == SSO_P_SHOW || prog_q == SSO_P_SEL;
   sso_led_t led_d;
   always_comb begin
      led_d.health_green = (prog_q == SSO_P_ARM) ? flick_q : ~in_show;
      led_d.health_red   = in_show;
      led_d.phase_green  = in_show ? (sel_q ? flick_q : flash_q) : bypass_q;
      led_d.fault_red    = ~in_show & (trip_q | rated_fault_q);
      led_d.trip_red     = rated_fault_q ? flash_q : trip_q;
      led_d.ack_auto     = auto_rst;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) leds_q <= '0;
      else leds_q <= led_d;
   end
   assign leds = leds_q;

   // interrupt events
   assign ev[EV_TRIP]  = trip_set & ~trip_q;
   assign ev[EV_BYP]   = bypass_q & ~bypass_prev_q;
   assign ev[EV_SAVE]  = save;
   assign ev[EV_RATED] = rated_fault & ~rated_fault_q;

   // checks
   a_class_off: assert property (@(posedge pclk) disable iff (!presetn)
      cls == CLS_OFF |=> acc_q == 32'h0 && !ovl_trip)
      else $error("overload active with class off");
   a_rated_block: assert property (@(posedge pclk) disable iff (!presetn)
      rated_fault && $past(rated_fault) && $past(rated_fault, 2) |->
      !motor_on && leds.trip_red == $past(flash_q))
      else $error("start not inhibited on rated fault");
   a_test_trip: assert property (@(posedge pclk) disable iff (!presetn)
      test_fire |=> trip_q && fault_relay ##1 !motor_on)
      else $error("test hold did not trip");
   a_bypass_rise: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(startup_complete_output) |-> $past(startup_detected) && full_voltage)
      else $error("bypass closed without startup");
   a_bypass_open: assert property (@(posedge pclk) disable iff (!presetn)
      !start_input |=> !bypass_close && !startup_complete_output)
      else $error("bypass held after start removal");
   a_follow_mode: assert property (@(posedge pclk) disable iff (!presetn)
      !mode_q |=> follow_relay == $past(start_input))
      else $error("follow relay mismatch");
   a_through_hold: assert property (@(posedge pclk) disable iff (!presetn)
      mode_q && start_fell && ramp_q > 16'h2 && $stable(mode_q) |=> follow_relay [*2])
      else $error("relay opened before ramp-down end");
   a_prog_red: assert property (@(posedge pclk) disable iff (!presetn)
      prog_q == SSO_P_SHOW |=> leds.health_red && !leds.health_green)
      else $error("health lamp not red in programming");
   a_save_exit: assert property (@(posedge pclk) disable iff (!presetn)
      save |=> prog_q == SSO_P_IDLE && mode_q == $past(sel_q) ##1 leds.health_green)
      else $error("save did not store mode and exit");
endmodule

// *** testbench/sso_op.sv ***
// operator model: start command, panel buttons, ramp-up feedback and motor current
module sso_op (
   input  wire logic pclk,
   output logic      start_input,
   output logic      ack_test_button,
   output logic      reset_behaviour_button,
   output logic      startup_detected,
   output logic [7:0] motor_current
);
   timeunit 1ns;
   timeprecision 1ns;
   // all lines released and idle at power up
   initial begin
      start_input = 1'b0;
      ack_test_button = 1'b0;
      reset_behaviour_button = 1'b0;
      startup_detected = 1'b0;
      motor_current = 8'h00;
   end
   // change one panel line just after a rising edge, held until the next call
   task automatic drive(input int s, input logic [7:0] v);
      @(posedge pclk);
      case (s)
         0: start_input <= v[0];
         1: ack_test_button <= v[0];
         2: reset_behaviour_button <= v[0];
         3: startup_detected <= v[0];
         default: motor_current <= v;
      endcase
   endtask
endmodule

// *** testbench/starter_output_and_setup_logic_bench.sv ***
// testbench of the starter control block with randomised settings
module starter_output_and_setup_logic_bench
   import sso_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = 4;
   localparam int FL = 8;
   localparam int FK = 2;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
   logic [7:0]  paddr, motor_current, rated;
   logic [31:0] pwdata, prdata, r;
   logic        start_input, ack_test_button, reset_behaviour_button, startup_detected;
   logic        motor_on, full_voltage, bypass_close, startup_complete_output;
   logic        follow_relay, fault_relay;
   sso_led_t    leds;
   int          error_cnt, n_tests, n, ramp;
   // 50 ns bus clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // cut a hang short, about twice the expected run
   initial begin
      repeat (90000) @(posedge pclk);
      error_cnt++;
      final_report();
   end
   sso_starter_ctrl #(.TICK_CYC(TK), .FLASH_MS(FL), .FLICK_MS(FK)) sso_starter_ctrl_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .start_input(start_input), .ack_test_button(ack_test_button),
      .reset_behaviour_button(reset_behaviour_button), .startup_detected(startup_detected),
      .motor_current(motor_current), .motor_on(motor_on), .full_voltage(full_voltage),
      .bypass_close(bypass_close), .startup_complete_output(startup_complete_output),
      .follow_relay(follow_relay), .fault_relay(fault_relay), .leds(leds), .irq(irq));
   sso_op sso_op_inst (
      .pclk(pclk), .start_input(start_input), .ack_test_button(ack_test_button),
      .reset_behaviour_button(reset_behaviour_button), .startup_detected(startup_detected),
      .motor_current(motor_current));
   // count and report one comparison
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         $display("mismatch %s expected %h seen %h", nm, x, g);
         error_cnt++;
      end
   endtask
   // one apb transfer: setup, access held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(nm, x, r);
   endtask
   task automatic op(input int s, input logic [7:0] v);
      sso_op_inst.drive(s, v);
   endtask
   // wait whole ms ticks, then look between edges
   task automatic ms(input int m);
      repeat (m * TK) @(posedge pclk);
      @(negedge pclk);
   endtask
   // cycles of one half period of a lamp bit; the first change may be a pattern onset
   task automatic half(input int b);
      logic v;
      repeat (2) begin
         @(negedge pclk);
         v = leds[b];
         while (leds[b] === v) @(negedge pclk);
      end
      v = leds[b];
      n = 0;
      while (leds[b] === v && n < 999) begin
         @(negedge pclk);
         n++;
      end
   endtask
   // ms of overload at 255 with rated 1 until the class trips
   function automatic int trip_ms(input int c);
      int t;
      t = (c == 1) ? int'(CLS10_MS) : (c == 2) ? int'(CLS15_MS) : int'(CLS20_MS);
      return (t * int'(OVL_MUL) + int'(OVL_DIV) * 254 - 1) / (int'(OVL_DIV) * 254);
   endfunction
   // verdict and end of run
   task automatic final_report();
      if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // main sequence
   initial begin
      error_cnt = 0;
      n_tests = 0;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      n = $urandom(32'h0EB986CB);
      rated = 8'($urandom_range(100, 1));
      ramp = $urandom_range(8, 4);
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      ms(1);
      chk("leds", 32'h20, 32'(leds));
      rd("ctrl", ADDR_CTRL, 32'(CTRL_RST));
      rd("rated", ADDR_RATED, 32'(RATED_RST));
      rd("ramp", ADDR_RAMP, 32'(RAMP_RST));
      rd("ist", ADDR_IST, 32'(IRQ_RST));
      rd("imask", ADDR_IMASK, 32'(IRQ_RST));
      rd("gap", 8'h18, 32'h0);
      chk("pslverr", 32'h1, 32'(e));
      wr(ADDR_STAT, 32'hFF);
      rd("stat", ADDR_STAT, 32'h0);
      wr(ADDR_RATED, {24'($urandom), rated});
      rd("rated", ADDR_RATED, 32'(rated));
      wr(ADDR_RAMP, {16'($urandom), 16'(ramp)});
      rd("ramp", ADDR_RAMP, 32'(ramp));
      wr(ADDR_CTRL, 32'h4);
      wr(ADDR_IMASK, 32'hF);
      ms(0);
      chk("auto", 32'h1, 32'(leds.ack_auto));
      // rated current above the limit: lamp flashes and no start
      wr(ADDR_RATED, 32'h65);
      op(0, 8'h01);
      half(1);
      chk("flash", FL * TK, n);
      chk("run", 32'h0, 32'(motor_on));
      rd("stat", ADDR_STAT, 32'h2);
      rd("ist", ADDR_IST, 32'h8);
      chk("irq", 32'h1, 32'(irq));
      wr(ADDR_IST, 32'h8);
      ms(0);
      chk("irq", 32'h0, 32'(irq));
      op(0, 8'h00);
      wr(ADDR_RATED, 32'h1);
      // start, ramp-up detected, stop in follow mode
      op(4, 8'h01);
      op(0, 8'h01);
      ms(0);
      ms(0);
      chk("start", 32'h3, 32'({motor_on, follow_relay}));
      op(3, 8'h01);
      ms(0);
      ms(0);
      chk("bypass", 32'h7, 32'({bypass_close, startup_complete_output, full_voltage}));
      rd("ist", ADDR_IST, 32'h2);
      op(0, 8'h00);
      ms(0);
      ms(0);
      chk("stop", 32'h0, 32'({bypass_close, startup_complete_output, follow_relay}));
      op(3, 8'h00);
      wr(ADDR_IST, 32'hF);
      // overload off, then every class against its computed trip time
      op(4, 8'hFF);
      ms(300);
      chk("off", 32'h0, 32'(fault_relay));
      for (int c = 1; c < 4; c++) begin
         wr(ADDR_CTRL, 32'(c));
         ms(trip_ms(c) - 3);
         chk("early", 32'h0, 32'(fault_relay));
         ms(5);
         chk("trip", 32'h1, 32'(fault_relay));
         wr(ADDR_CTRL, 32'h0);
         op(1, 8'h01);
         ms(10);
         op(1, 8'h00);
         ms(1);
         chk("ack", 32'h0, 32'(fault_relay));
      end
      // trip test by a long press while running
      op(4, 8'h01);
      wr(ADDR_CTRL, 32'h1);
      wr(ADDR_IST, 32'hF);
      op(0, 8'h01);
      op(1, 8'h01);
      ms(4995);
      chk("hold", 32'h0, 32'(fault_relay));
      ms(10);
      chk("test", 32'h3, 32'({fault_relay, leds.trip_red}));
      chk("halt", 32'h0, 32'(motor_on));
      op(1, 8'h00);
      op(0, 8'h00);
      ms(2);
      chk("latch", 32'h1, 32'(fault_relay));
      rd("ist", ADDR_IST, 32'h1);
      wr(ADDR_IMASK, 32'h4);
      ms(0);
      chk("mask", 32'h0, 32'(irq));
      op(1, 8'h01);
      ms(10);
      op(1, 8'h00);
      ms(1);
      chk("clear", 32'h0, 32'(fault_relay));
      wr(ADDR_IST, 32'hF);
      // programming: enter, show, toggle, save
      op(2, 8'h01);
      ms(2010);
      half(5);
      chk("arm", FK * TK, n);
      op(1, 8'h01);
      ms(1010);
      chk("show", 32'h1, 32'({leds.health_green, leds.health_red}));
      half(3);
      chk("follow", FL * TK, n);
      op(1, 8'h00);
      op(2, 8'h00);
      ms(5);
      op(2, 8'h01);
      ms(5);
      op(2, 8'h00);
      half(3);
      chk("thru", FK * TK, n);
      op(1, 8'h01);
      ms(1010);
      op(1, 8'h00);
      ms(1);
      chk("saved", 32'h2, 32'({leds.health_green, leds.health_red}));
      rd("mode", ADDR_STAT, 32'h10);
      chk("irq", 32'h1, 32'(irq));
      // through-stop relay holds for the ramp-down time
      op(0, 8'h01);
      ms(3);
      op(0, 8'h00);
      ms(ramp - 2);
      chk("ramp", 32'h1, 32'(follow_relay));
      ms(4);
      chk("ramp end", 32'h0, 32'(follow_relay));
      final_report();
   end
endmodule
